// >>> hw/mbd_decoder.sv
`timescale 1ns/10ps
module mbd_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Channel configuration
  input wire logic [1:0] input_mode,
  // Modulator pin, asynchronous to clk
  input wire logic modulator_data_line,
  // Recovered bit stream
  output logic bit_valid,
  output logic bit_data,
  output logic bit_window_start,
  output logic bit_strobe,
  input wire logic bit_ready,
  // Status
  output logic calibrated,
  output logic [15:0] applied_half_period,
  output logic [15:0] measuring_half_period,
  output logic [9:0] window_edge_count,
  output logic bit_overrun
);

  mbd_pkg::mbd_dec_state_t r_reg;
  mbd_pkg::mbd_dec_state_t r_next;
  logic line_edge;
  logic [15:0] interval;
  logic [15:0] since_mid;
  logic [15:0] new_min;
  logic push_valid;
  mbd_pkg::mbd_bit_t push_bit;
  logic push_ready;
  mbd_pkg::mbd_bit_t out_bit;

  // Transition seen only after both synchroniser stages
  assign line_edge = r_reg.sync2 ^ r_reg.prev;
  assign interval = mbd_pkg::sat_inc(r_reg.edge_gap);
  assign since_mid = mbd_pkg::sat_inc(r_reg.mid_gap);
  // Shortest gap wins; a glitch or uneven duty pulls it low
  assign new_min = (interval < r_reg.min_half) ? interval : r_reg.min_half;

  always_comb begin
    r_next = r_reg;
    push_valid = 1'b0;
    push_bit = '0;
    r_next.sync1 = modulator_data_line;
    r_next.sync2 = r_reg.sync1;
    r_next.prev = r_reg.sync2;
    r_next.edge_gap = interval;
    r_next.mid_gap = since_mid;
    if (input_mode != mbd_pkg::MODE_MANCHESTER) begin
      r_next.state = mbd_pkg::MBD_OFF;
      r_next.edge_gap = mbd_pkg::CNT_SAT;
      r_next.mid_gap = mbd_pkg::CNT_ZERO;
      r_next.edges = '0;
      r_next.min_half = mbd_pkg::HALF_UNMEASURED;
      r_next.act_half = mbd_pkg::HALF_UNMEASURED;
      r_next.win_pending = 1'b0;
    end else begin
      case (r_reg.state)
        mbd_pkg::MBD_OFF: begin
          r_next.state = mbd_pkg::MBD_CAL;
          r_next.edge_gap = mbd_pkg::CNT_SAT;
        end
        mbd_pkg::MBD_CAL, mbd_pkg::MBD_RUN: begin
          if (line_edge) begin
            r_next.edge_gap = mbd_pkg::CNT_ZERO;
            r_next.min_half = new_min;
            r_next.edges = r_reg.edges + 10'h001;
            if (r_reg.edges == mbd_pkg::WINDOW_LAST_EDGE) begin
              // Result only steers sampling in the next window
              r_next.act_half = new_min;
              r_next.min_half = mbd_pkg::HALF_UNMEASURED;
              r_next.state = mbd_pkg::MBD_RUN;
              r_next.win_pending = 1'b1;
            end
            // Fixed integer threshold; phase drift near integer rates can skip a bit
            if ((r_reg.state == mbd_pkg::MBD_RUN) &&
                ({1'b0, since_mid} >= mbd_pkg::mid_threshold(r_reg.act_half))) begin
              r_next.mid_gap = mbd_pkg::CNT_ZERO;
              push_valid = 1'b1;
              push_bit.data = r_reg.sync2;
              push_bit.win_start = r_reg.win_pending;
              if (push_ready) begin
                r_next.win_pending = (r_reg.edges == mbd_pkg::WINDOW_LAST_EDGE);
              end else begin
                r_next.overrun = 1'b1;
              end
            end
          end
        end
        default: begin
          r_next.state = mbd_pkg::MBD_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= mbd_pkg::MBD_DEC_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Line cannot be stalled, so a full buffer shows as sticky overrun
  mbd_pair_buf u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_bit(push_bit),
    .in_ready(push_ready),
    .out_valid(bit_valid),
    .out_bit(out_bit),
    .out_ready(bit_ready)
  );

  assign bit_data = out_bit.data;
  assign bit_window_start = out_bit.win_start;
  assign bit_strobe = bit_valid && bit_ready;
  assign calibrated = (r_reg.state == mbd_pkg::MBD_RUN);
  assign applied_half_period = r_reg.act_half;
  assign measuring_half_period = r_reg.min_half;
  assign window_edge_count = r_reg.edges;
  assign bit_overrun = r_reg.overrun;

endmodule // mbd_decoder

// >>> hw/mbd_pair_buf.sv
`timescale 1ns/10ps
module mbd_pair_buf (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input mbd_pkg::mbd_bit_t in_bit,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output mbd_pkg::mbd_bit_t out_bit,
  input wire logic out_ready
);

  mbd_pkg::mbd_buf_state_t r_reg;
  mbd_pkg::mbd_buf_state_t r_next;
  logic push;
  logic pop;

  assign in_ready = (r_reg.count != mbd_pkg::BUF_DEPTH);
  assign out_valid = (r_reg.count != 2'h0);
  assign out_bit = r_reg.slot[0];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    r_next = r_reg;
    if (pop) begin
      r_next.slot[0] = r_reg.slot[1];
    end
    if (push) begin
      if ((r_reg.count == 2'h0) || ((r_reg.count == 2'h1) && pop)) begin
        r_next.slot[0] = in_bit;
      end else begin
        r_next.slot[1] = in_bit;
      end
    end
    case ({push, pop})
      2'h2: r_next.count = r_reg.count + 2'h1;
      2'h1: r_next.count = r_reg.count - 2'h1;
      default: r_next.count = r_reg.count;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= mbd_pkg::MBD_BUF_RST;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule // mbd_pair_buf

// >>> inc/mbd_pkg.sv
// Overview of operation
// - Input mode 2 selects Manchester decoding of the modulator data line.
// - Line is oversampled by the core clock; windows span 1024 line transitions.
// - Period measured in one window is applied only during the next window.
// - A single line glitch can corrupt the measured period and later bits.
// - Near-integer bit rates may skip a bit before the next window applies.
// - Rise/fall delay mismatch over one clock shortens the measured period.
package mbd_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned EDGE_W = 10;
  localparam logic [1:0] MODE_MANCHESTER = 2'h2;
  localparam logic [EDGE_W-1:0] WINDOW_LAST_EDGE = 10'h3FF;
  localparam logic [CNT_W-1:0] HALF_UNMEASURED = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_SAT = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [1:0] {
    MBD_OFF,
    MBD_CAL,
    MBD_RUN
  } mbd_state_t;

  typedef struct packed {
    logic data;
    logic win_start;
  } mbd_bit_t;

  typedef struct packed {
    mbd_bit_t [1:0] slot;
    logic [1:0] count;
  } mbd_buf_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    mbd_state_t state;
    logic [CNT_W-1:0] edge_gap;
    logic [CNT_W-1:0] mid_gap;
    logic [EDGE_W-1:0] edges;
    logic [CNT_W-1:0] min_half;
    logic [CNT_W-1:0] act_half;
    logic win_pending;
    logic overrun;
  } mbd_dec_state_t;

  localparam mbd_buf_state_t MBD_BUF_RST = '0;

  localparam mbd_dec_state_t MBD_DEC_RST = '{
    sync1: 1'b0,
    sync2: 1'b0,
    prev: 1'b0,
    state: MBD_OFF,
    edge_gap: CNT_SAT,
    mid_gap: CNT_ZERO,
    edges: 10'h000,
    min_half: HALF_UNMEASURED,
    act_half: HALF_UNMEASURED,
    win_pending: 1'b0,
    overrun: 1'b0
  };

  // Saturating so a stalled line never wraps into a short interval
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == CNT_SAT) ? v : v + 16'h0001;
  endfunction

  // Three quarters of a bit: separates mid-bit edges from boundary edges
  function automatic logic [CNT_W:0] mid_threshold(input logic [CNT_W-1:0] half);
    mid_threshold = {1'b0, half} + {2'h0, half[CNT_W-1:1]};
  endfunction

endpackage

// >>> tb/mbd_decoder_asserts.sv
`timescale 1ns/10ps
module mbd_decoder_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic [1:0] input_mode,
  input wire logic bit_valid,
  input wire logic bit_data,
  input wire logic bit_strobe,
  input wire logic bit_ready,
  input wire logic calibrated,
  input wire logic [15:0] applied_half_period,
  input wire logic [15:0] measuring_half_period,
  input wire logic [9:0] window_edge_count,
  input wire logic bit_overrun
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Mode must be 2 on both sides of a step, else the mode-off clear of applied_half_period wins
  sequence seq_stall;
    bit_valid && !bit_ready && input_mode == 2'h2 ##1 input_mode == 2'h2;
  endsequence
  sequence seq_steady;
    calibrated && input_mode == 2'h2 && window_edge_count != 10'h3FF ##1 input_mode == 2'h2;
  endsequence
  AST_MODE_OFF: assert property (input_mode != 2'h2 |=> !calibrated &&
    applied_half_period == 16'hFFFF) else $error("mode off did not clear");
  AST_STROBE: assert property (bit_strobe == (bit_valid && bit_ready))
    else $error("strobe not valid and ready");
  AST_HOLD: assert property (seq_stall |-> bit_valid && $stable(bit_data))
    else $error("bit lost during stall");
  AST_APPLY_HOLD: assert property (seq_steady |-> $stable(applied_half_period))
    else $error("period changed inside window");
  AST_APPLY_MIN: assert property ($rose(calibrated) |->
    $past(window_edge_count) == 10'h3FF && applied_half_period <= $past(measuring_half_period))
    else $error("window apply wrong");
  AST_NO_EARLY_BIT: assert property ($rose(bit_valid) |-> $past(calibrated))
    else $error("bit before calibration");
  AST_OVR_STICKY: assert property (bit_overrun |=> bit_overrun)
    else $error("overrun flag dropped");
  AST_OVR_CAUSE: assert property ($rose(bit_overrun) |-> $past(bit_valid))
    else $error("overrun without full buffer");
  AST_EDGE_STEP: assert property (input_mode == 2'h2 && $past(input_mode) == 2'h2 |=>
    window_edge_count == $past(window_edge_count) ||
    window_edge_count == $past(window_edge_count) + 10'h001) else $error("edge count jump");
endmodule // mbd_decoder_asserts
bind mbd_decoder mbd_decoder_asserts chk_u (.clk(clk), .rst_n(rst_n), .input_mode(input_mode),
  .bit_valid(bit_valid), .bit_data(bit_data), .bit_strobe(bit_strobe), .bit_ready(bit_ready),
  .calibrated(calibrated), .applied_half_period(applied_half_period),
  .measuring_half_period(measuring_half_period), .window_edge_count(window_edge_count),
  .bit_overrun(bit_overrun));

// >>> tb/mbd_decoder_bench.sv
`timescale 1ns/10ps
module mbd_decoder_bench;
  logic clk, rst_n, line, val, bit_ready, bit_valid, bit_data, bit_strobe, calibrated, bit_overrun;
  logic bit_window_start;
  logic [1:0] input_mode;
  logic [15:0] applied_half_period, measuring_half_period;
  logic [9:0] window_edge_count;
  int num_errors, comparisons, cycles;
  mbd_mod_model mod_u (.run(1'b1), .val(val), .line(line));
  mbd_decoder dut_u (.clk(clk), .rst_n(rst_n), .input_mode(input_mode),
    .modulator_data_line(line), .bit_valid(bit_valid), .bit_data(bit_data),
    .bit_window_start(bit_window_start), .bit_strobe(bit_strobe), .bit_ready(bit_ready),
    .calibrated(calibrated), .applied_half_period(applied_half_period),
    .measuring_half_period(measuring_half_period), .window_edge_count(window_edge_count),
    .bit_overrun(bit_overrun));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic t_off();
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        @(posedge clk);
        input_mode <= m[1:0];
        repeat (40) tick();
        check({15'h0, calibrated}, 16'h0000);
        check(applied_half_period, 16'hFFFF);
        check({6'h0, window_edge_count}, 16'h0000);
      end
    end
  endtask
  task automatic t_cal();
    @(posedge clk);
    input_mode <= 2'h2;
    repeat (60) tick();
    check(applied_half_period, 16'hFFFF);
    check(measuring_half_period, 16'h0005);
    for (int i = 0; i < 8000 && calibrated !== 1'b1; i++) tick();
    check({15'h0, calibrated}, 16'h0001);
    check(applied_half_period, 16'h0005);
    for (int i = 0; i < 100 && bit_strobe !== 1'b1; i++) tick();
    check({15'h0, bit_window_start}, 16'h0001);
    tick();
    for (int i = 0; i < 100 && bit_strobe !== 1'b1; i++) tick();
    check({15'h0, bit_window_start}, 16'h0000);
    repeat (100) tick();
    check(applied_half_period, 16'h0005);
  endtask
  task automatic t_bits(input logic v);
    val = v;
    @(posedge clk);
    bit_ready <= 1'b1;
    // Early bits after a change are skipped, not trusted
    for (int n = 0; n < 7; n++) begin
      for (int i = 0; i < 100 && bit_strobe !== 1'b1; i++) tick();
      if (n > 2) check({15'h0, bit_strobe}, 16'h0001);
      if (n > 2) check({15'h0, bit_data}, {15'h0, v});
      tick();
    end
  endtask
  task automatic t_stall();
    check({15'h0, bit_overrun}, 16'h0000);
    @(posedge clk);
    bit_ready <= 1'b0;
    repeat (60) tick();
    check({15'h0, bit_valid}, 16'h0001);
    check({15'h0, bit_overrun}, 16'h0001);
    @(posedge clk);
    bit_ready <= 1'b1;
  endtask
  task automatic close_out();
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Full run is near 6000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    rst_n = 1'b0;
    input_mode = 2'h0;
    // Ready from the start, so bits after calibration do not overrun until t_stall drops it
    bit_ready = 1'b1;
    val = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_off();
    t_cal();
    t_bits(1'b1);
    t_bits(1'b0);
    t_stall();
    t_off();
    close_out();
  end
endmodule // mbd_decoder_bench

// >>> tb/mbd_mod_model.sv
`timescale 1ns/10ps
module mbd_mod_model (
  // Control
  input wire logic run,
  input wire logic val,
  // Line
  output logic line
);
  logic cur;
  // Half bit of 5.15 clocks, equal halves, clean line
  initial begin
    line = 1'b0;
    cur = 1'b0;
    forever begin
      if (run) begin
        // Data only changes on a bit boundary, so no half-bit of a stale value
        cur = val;
        #51.5 line = ~cur;
        #51.5 line = cur;
      end else #10;
    end
  end
endmodule // mbd_mod_model
